// ---- dopag_decoder_model.sv ----
`timescale 1ns/10ps
module dopag_decoder_model (
    // Decoded fields from the bench.
    input wire logic go,
    input wire logic acc,
    input wire logic dst,
    input wire logic fr,
    input wire logic hd,
    input wire logic [7:0] f,
    input wire logic [7:0] w,
    input wire logic [5:0] hi,
    // Toward the block.
    output logic op_valid,
    output logic [15:0] opcode,
    output logic op_file_ref,
    output logic op_has_dest,
    output logic [7:0] w_value
);
    // Fields packed as the add-W-to-file layout; upper bits are free.
    assign opcode = {hi, dst, acc, f};
    assign op_valid = go;
    assign op_file_ref = fr;
    assign op_has_dest = hd;
    assign w_value = w;
endmodule

// ---- dopag_pkg.sv ----
package dopag_pkg;

    // Data space geometry.
    localparam int ADDR_W = 12;
    localparam int FILE_W = 8;
    localparam int BANK_W = 4;
    localparam int OPC_W = 16;
    localparam int NUM_PTR = 3;
    localparam int IND_OPS = 5;

    // Opcode field positions of the byte-oriented add-W-to-file layout.
    localparam int OPC_FILE_LSB = 0;
    localparam int OPC_A_BIT = 8;
    localparam int OPC_D_BIT = 9;

    // File field limits for access-forced operands.
    localparam logic [FILE_W-1:0] IDX_LIMIT = 8'h5f;
    localparam logic [FILE_W-1:0] ACC_SPLIT_STD = 8'h80;
    localparam logic [FILE_W-1:0] ACC_SPLIT_EXT = 8'h60;
    localparam logic [BANK_W-1:0] BANK_ZERO = 4'h0;
    localparam logic [BANK_W-1:0] BANK_TOP = 4'hf;

    // Indirect operand locations: base is the offset-from-pointer operand.
    localparam logic [ADDR_W-1:0] IND_BASE0 = 12'hfeb;
    localparam logic [ADDR_W-1:0] IND_BASE1 = 12'hfe3;
    localparam logic [ADDR_W-1:0] IND_BASE2 = 12'hfdb;
    localparam logic [2:0] IND_PLUSW = 3'h0;
    localparam logic [2:0] IND_PREINC = 3'h1;
    localparam logic [2:0] IND_POSTDEC = 3'h2;
    localparam logic [2:0] IND_POSTINC = 3'h3;
    localparam logic [2:0] IND_PLAIN = 3'h4;
    localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;

    // Register indices on the software port.
    localparam logic [3:0] REG_P0_LO = 4'h0;
    localparam logic [3:0] REG_P0_HI = 4'h1;
    localparam logic [3:0] REG_P1_LO = 4'h2;
    localparam logic [3:0] REG_P1_HI = 4'h3;
    localparam logic [3:0] REG_P2_LO = 4'h4;
    localparam logic [3:0] REG_P2_HI = 4'h5;
    localparam logic [3:0] REG_BANK = 4'h6;
    localparam logic [3:0] REG_CFG = 4'h7;
    localparam logic [3:0] REG_LAST_LO = 4'h8;
    localparam logic [3:0] REG_LAST_HI = 4'h9;

    // Reset values.
    localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
    localparam logic EXT_RST = 1'b0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    typedef enum logic [2:0] {
        DOPAG_MODE_NONE = 3'h0,
        DOPAG_MODE_ACCESS = 3'h1,
        DOPAG_MODE_BANKED = 3'h3,
        DOPAG_MODE_INDEXED = 3'h2,
        DOPAG_MODE_INDIRECT = 3'h6
    } dopag_mode_t;

endpackage

// ---- dopag_regs.sv ----
`timescale 1ns/10ps
module dopag_regs (
    // Clocking.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Software port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pointer update from indirect operands.
    input wire logic upd_en,
    input wire logic [1:0] upd_sel,
    input wire logic [dopag_pkg::ADDR_W-1:0] upd_val,
    // Status shown to software.
    input wire logic [dopag_pkg::ADDR_W-1:0] last_addr,
    input wire logic [2:0] last_mode,
    // Steering state.
    output logic [dopag_pkg::ADDR_W-1:0] ptr0,
    output logic [dopag_pkg::ADDR_W-1:0] ptr1,
    output logic [dopag_pkg::ADDR_W-1:0] ptr2,
    output logic [dopag_pkg::BANK_W-1:0] bank,
    output logic ext_en
);
    import dopag_pkg::*;

    logic [ADDR_W-1:0] ptr_ff [NUM_PTR];
    logic [ADDR_W-1:0] nxt_ptr [NUM_PTR];
    logic [BANK_W-1:0] bank_ff;
    logic [BANK_W-1:0] nxt_bank;
    logic ext_ff;
    logic nxt_ext;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // A software write to a pointer byte beats a same-cycle auto step.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
            localparam logic [3:0] LO = 4'(2 * gi);
            localparam logic [3:0] HI = 4'(2 * gi + 1);
            always_comb begin
                nxt_ptr[gi] = ptr_ff[gi];
                if (upd_en && upd_sel == 2'(gi)) begin
                    nxt_ptr[gi] = upd_val;
                end
                if (reg_wr && reg_addr == LO) begin
                    nxt_ptr[gi][7:0] = reg_wdata;
                end
                if (reg_wr && reg_addr == HI) begin
                    nxt_ptr[gi][11:8] = reg_wdata[3:0]; // RULE_13
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_bank = bank_ff;
        nxt_ext = ext_ff;
        nxt_rdata = RDATA_RST;
        if (reg_wr && reg_addr == REG_BANK) begin
            nxt_bank = reg_wdata[BANK_W-1:0];
        end
        if (reg_wr && reg_addr == REG_CFG) begin
            nxt_ext = reg_wdata[0]; // RULE_01
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_P0_LO: nxt_rdata = ptr_ff[0][7:0];
                REG_P0_HI: nxt_rdata = {4'h0, ptr_ff[0][11:8]};
                REG_P1_LO: nxt_rdata = ptr_ff[1][7:0];
                REG_P1_HI: nxt_rdata = {4'h0, ptr_ff[1][11:8]};
                REG_P2_LO: nxt_rdata = ptr_ff[2][7:0];
                REG_P2_HI: nxt_rdata = {4'h0, ptr_ff[2][11:8]};
                REG_BANK: nxt_rdata = {4'h0, bank_ff};
                REG_CFG: nxt_rdata = {7'h00, ext_ff};
                REG_LAST_LO: nxt_rdata = last_addr[7:0];
                REG_LAST_HI: nxt_rdata = {1'b0, last_mode, last_addr[11:8]};
                default: nxt_rdata = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PTR; i++) begin
                ptr_ff[i] <= PTR_RST;
            end
            bank_ff <= BANK_RST;
            ext_ff <= EXT_RST;
            rdata_ff <= RDATA_RST;
        end else if (ce) begin
            for (int i = 0; i < NUM_PTR; i++) begin
                ptr_ff[i] <= nxt_ptr[i];
            end
            bank_ff <= nxt_bank;
            ext_ff <= nxt_ext;
            rdata_ff <= nxt_rdata;
        end
    end

    assign ptr0 = ptr_ff[0];
    assign ptr1 = ptr_ff[1];
    assign ptr2 = ptr_ff[2];
    assign bank = bank_ff;
    assign ext_en = ext_ff;
    assign reg_rdata = rdata_ff;

endmodule

// ---- dopag_resolve.sv ----
`timescale 1ns/10ps
module dopag_resolve (
    // Operand fields.
    input wire logic ext_en,
    input wire logic acc_bit,
    input wire logic [dopag_pkg::FILE_W-1:0] file,
    // Banking state.
    input wire logic [dopag_pkg::BANK_W-1:0] bank,
    input wire logic [dopag_pkg::ADDR_W-1:0] frame_ptr,
    // Result.
    output logic [dopag_pkg::ADDR_W-1:0] addr,
    output dopag_pkg::dopag_mode_t mode
);
    import dopag_pkg::*;

    always_comb begin
        if (acc_bit) begin
            addr = {bank, file}; // RULE_06 RULE_14
            mode = DOPAG_MODE_BANKED;
        end else if (ext_en && file <= IDX_LIMIT) begin // RULE_01 RULE_02
            // Sum wraps in 12 bits and touches no status flag.
            addr = frame_ptr + {BANK_ZERO, file}; // RULE_03 RULE_07 RULE_17
            mode = DOPAG_MODE_INDEXED;
        end else if (ext_en) begin
            // Low access locations are hidden behind the window here.
            addr = {BANK_TOP, file}; // RULE_04 RULE_05
            mode = DOPAG_MODE_ACCESS;
        end else begin
            addr = {(file >= ACC_SPLIT_STD) ? BANK_TOP : BANK_ZERO,
                    file}; // RULE_16
            mode = DOPAG_MODE_ACCESS;
        end
    end

endmodule

// ---- dopag_top.sv ----
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: Offset addressing exists only while the extended set bit is one.
// RULE_02: Set on, access bit zero and field up to 5Fh select offset mode.
// RULE_03: Offset mode addresses frame pointer plus the unsigned file field.
// RULE_04: Set on, access bit zero and field 60h or more use the top bank.
// RULE_05: With it set, access locations below 60h cannot be reached directly.
// RULE_06: Access bit one joins the 4-bit bank select with the file field.
// RULE_07: The window runs from the frame pointer to that pointer plus 95.
// RULE_08: Indirect operands, frame pointer ones too, keep plain indirect use.
// RULE_09: Pointer pairs zero and one behave alike with the set on or off.
// RULE_10: Inherent and literal instructions get no operand address at all.
// RULE_11: Memory size, linear space and register map stay as they are.
// RULE_12: Access bit and destination bit sit just above the 8-bit file field.
// RULE_13: Pointer pairs hold 12 bits; the high byte's upper nibble is absent.
// RULE_14: Banked addresses are bank select concatenated with the file field.
// RULE_15: Destination bit one writes the file, zero the working register.
// RULE_16: Set off, forced fields 00h-7Fh use bank zero, 80h-FFh the top bank.
// RULE_17: The pointer sum wraps in 12 bits and changes no status flag.
module dopag_top #(
    parameter int REG_AW = 4
) (
    // Clock, reset and enable.
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Software register port.
    input wire logic [REG_AW-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Instruction from the decoder.
    input wire logic OP_VALID,
    input wire logic [dopag_pkg::OPC_W-1:0] OPCODE,
    input wire logic OP_FILE_REF,
    input wire logic OP_HAS_DEST,
    input wire logic [7:0] W_VALUE,
    // Resolved operand toward data space.
    output logic ADDR_VALID,
    output logic [dopag_pkg::ADDR_W-1:0] DATA_ADDR,
    output dopag_pkg::dopag_mode_t ADDR_MODE,
    output logic WR_TO_FILE,
    output logic WR_TO_W
);
    import dopag_pkg::*;

    generate
        if (REG_AW < 4) begin : g_bad_aw
            $error("REG_AW must be at least 4");
        end
    endgenerate

    // Reset release through two flops; assertion stays asynchronous.
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // Addresses above the register window read as zero.
    logic [3:0] reg_idx;
    logic reg_in_range;

    always_comb begin
        reg_in_range = (REG_ADDR >> 4) == '0;
        reg_idx = REG_ADDR[3:0];
    end

    // Opcode fields.
    logic [FILE_W-1:0] op_file;
    logic op_acc;
    logic op_dest;

    always_comb begin
        op_file = OPCODE[OPC_FILE_LSB +: FILE_W];
        op_acc = OPCODE[OPC_A_BIT]; // RULE_12
        op_dest = OPCODE[OPC_D_BIT]; // RULE_12
    end

    // Register file.
    logic [ADDR_W-1:0] ptr [NUM_PTR];
    logic [BANK_W-1:0] bank;
    logic ext_en;
    logic upd_en;
    logic [1:0] upd_sel;
    logic [ADDR_W-1:0] upd_val;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    dopag_mode_t mode_ff;
    dopag_mode_t nxt_mode;

    dopag_regs u_regs (
        .clk(CLK),
        .rst_n(rst_n),
        .ce(CE),
        .reg_addr(reg_idx),
        .reg_wdata(REG_WDATA),
        .reg_wr(REG_WR && reg_in_range),
        .reg_rd(REG_RD && reg_in_range),
        .reg_rdata(REG_RDATA),
        .upd_en(upd_en),
        .upd_sel(upd_sel),
        .upd_val(upd_val),
        .last_addr(addr_ff),
        .last_mode(mode_ff),
        .ptr0(ptr[0]),
        .ptr1(ptr[1]),
        .ptr2(ptr[2]),
        .bank(bank),
        .ext_en(ext_en)
    );

    // Direct resolution. The map itself never changes with the set.
    logic [ADDR_W-1:0] dir_addr;
    dopag_mode_t dir_mode;

    dopag_resolve u_resolve (
        .ext_en(ext_en),
        .acc_bit(op_acc),
        .file(op_file),
        .bank(bank),
        .frame_ptr(ptr[2]),
        .addr(dir_addr),
        .mode(dir_mode)
    ); // RULE_11

    // Returns which indirect operand of a pair an address names, if any.
    function automatic logic [3:0] ind_decode(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        if (addr >= base && diff < ADDR_W'(IND_OPS)) begin
            ind_decode = {1'b1, diff[2:0]};
        end else begin
            ind_decode = 4'h0;
        end
    endfunction

    localparam logic [ADDR_W-1:0] IND_BASES [NUM_PTR] = '{
        IND_BASE0, IND_BASE1, IND_BASE2
    };

    logic [3:0] ind_hit [NUM_PTR];
    logic [ADDR_W-1:0] ind_addr [NUM_PTR];
    logic [ADDR_W-1:0] ind_next [NUM_PTR];
    logic [ADDR_W-1:0] w_sext;

    assign w_sext = {{(ADDR_W - 8){W_VALUE[7]}}, W_VALUE};

    // Every pair uses the same indirect rules, frame pointer included.
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PTR; gp++) begin : g_ind
            always_comb begin
                ind_hit[gp] = ind_decode(dir_addr,
                    IND_BASES[gp]); // RULE_08 RULE_09
                ind_addr[gp] = ptr[gp];
                ind_next[gp] = ptr[gp];
                case (ind_hit[gp][2:0])
                    IND_PLUSW: ind_addr[gp] = ptr[gp] + w_sext;
                    IND_PREINC: begin
                        ind_addr[gp] = ptr[gp] + PTR_STEP;
                        ind_next[gp] = ptr[gp] + PTR_STEP;
                    end
                    IND_POSTDEC: ind_next[gp] = ptr[gp] - PTR_STEP;
                    IND_POSTINC: ind_next[gp] = ptr[gp] + PTR_STEP;
                    default: ind_addr[gp] = ptr[gp];
                endcase
            end
        end
    endgenerate

    // Offset-mode results are final: the window never becomes indirect.
    logic take_op;
    logic ind_any;
    logic [1:0] ind_sel;

    always_comb begin
        take_op = OP_VALID && OP_FILE_REF; // RULE_10
        ind_any = 1'b0;
        ind_sel = 2'h0;
        for (int i = NUM_PTR - 1; i >= 0; i--) begin
            if (ind_hit[i][3]) begin
                ind_any = 1'b1;
                ind_sel = 2'(i);
            end
        end
        if (dir_mode == DOPAG_MODE_INDEXED) begin
            ind_any = 1'b0;
        end
    end

    always_comb begin
        upd_en = 1'b0;
        upd_sel = ind_sel;
        upd_val = ind_next[ind_sel];
        if (take_op && ind_any && ind_next[ind_sel] != ptr[ind_sel]) begin
            upd_en = 1'b1; // RULE_08
        end
    end

    // Output stage.
    logic valid_ff;
    logic nxt_valid;
    logic to_file_ff;
    logic nxt_to_file;
    logic to_w_ff;
    logic nxt_to_w;

    always_comb begin
        nxt_valid = take_op;
        nxt_addr = addr_ff;
        nxt_mode = mode_ff;
        nxt_to_file = 1'b0;
        nxt_to_w = 1'b0;
        if (take_op) begin
            nxt_addr = ind_any ? ind_addr[ind_sel] : dir_addr;
            nxt_mode = ind_any ? DOPAG_MODE_INDIRECT : dir_mode;
            nxt_to_file = !OP_HAS_DEST || op_dest; // RULE_15
            nxt_to_w = OP_HAS_DEST && !op_dest; // RULE_15
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            addr_ff <= PTR_RST;
            mode_ff <= DOPAG_MODE_NONE;
            to_file_ff <= 1'b0;
            to_w_ff <= 1'b0;
        end else if (CE) begin
            valid_ff <= nxt_valid;
            addr_ff <= nxt_addr;
            mode_ff <= nxt_mode;
            to_file_ff <= nxt_to_file;
            to_w_ff <= nxt_to_w;
        end
    end

    assign ADDR_VALID = valid_ff;
    assign DATA_ADDR = addr_ff;
    assign ADDR_MODE = mode_ff;
    assign WR_TO_FILE = to_file_ff;
    assign WR_TO_W = to_w_ff;

endmodule

// ---- dopag_top_properties.sv ----
`timescale 1ns/10ps
module dopag_top_properties
    import dopag_pkg::*;
#(
    parameter int REG_AW = 4
) (
    // Clock, reset and enable.
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Software register port.
    input wire logic [REG_AW-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Instruction side.
    input wire logic OP_VALID,
    input wire logic [dopag_pkg::OPC_W-1:0] OPCODE,
    input wire logic OP_FILE_REF,
    input wire logic OP_HAS_DEST,
    input wire logic [7:0] W_VALUE,
    // Resolved operand.
    input wire logic ADDR_VALID,
    input wire logic [dopag_pkg::ADDR_W-1:0] DATA_ADDR,
    input wire dopag_pkg::dopag_mode_t ADDR_MODE,
    input wire logic WR_TO_FILE,
    input wire logic WR_TO_W
);
    import dopag_pkg::*;
    logic ext_ff, nxt_ext, take, acc;
    logic [3:0] bank_ff, nxt_bank;
    logic [7:0] fld;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    assign take = CE && OP_VALID && OP_FILE_REF;
    assign acc = OPCODE[OPC_A_BIT];
    assign fld = OPCODE[7:0];
    // Shadow of the steering bits, so checks need no view of the body.
    always_comb begin
        nxt_ext = ext_ff;
        nxt_bank = bank_ff;
        if (CE && REG_WR && REG_ADDR == REG_AW'(REG_CFG)) begin
            nxt_ext = REG_WDATA[0];
        end
        if (CE && REG_WR && REG_ADDR == REG_AW'(REG_BANK)) begin
            nxt_bank = REG_WDATA[3:0];
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_ff <= EXT_RST;
            bank_ff <= BANK_RST;
        end else begin
            ext_ff <= nxt_ext;
            bank_ff <= nxt_bank;
        end
    end
    property p_pulse; take |=> ADDR_VALID; endproperty
    property p_inherent;
        CE && OP_VALID && !OP_FILE_REF |=> !ADDR_VALID;
    endproperty
    property p_banked;
        take && acc |=> ADDR_MODE == DOPAG_MODE_INDIRECT || (ADDR_MODE ==
            DOPAG_MODE_BANKED && DATA_ADDR == {$past(bank_ff), $past(fld)});
    endproperty
    property p_indexed;
        take && !acc && ext_ff && fld <= IDX_LIMIT |=>
            ADDR_MODE == DOPAG_MODE_INDEXED;
    endproperty
    property p_forced;
        take && !acc && ext_ff && fld >= ACC_SPLIT_EXT |=> ADDR_MODE ==
            DOPAG_MODE_INDIRECT || DATA_ADDR == {BANK_TOP, $past(fld)};
    endproperty
    property p_std;
        take && !acc && !ext_ff |=> ADDR_MODE == DOPAG_MODE_INDIRECT ||
            DATA_ADDR == {$past(fld[7]) ? BANK_TOP : BANK_ZERO, $past(fld)};
    endproperty
    property p_no_idx;
        take && !ext_ff |=> ADDR_MODE != DOPAG_MODE_INDEXED;
    endproperty
    property p_dest_w;
        take |=> WR_TO_W == ($past(OP_HAS_DEST) && !$past(OPCODE[OPC_D_BIT]));
    endproperty
    property p_dest_f;
        take |=> WR_TO_FILE ==
            (!$past(OP_HAS_DEST) || $past(OPCODE[OPC_D_BIT]));
    endproperty
    property p_hi_nibble;
        CE && REG_RD && REG_ADDR[0] && REG_ADDR < REG_AW'(REG_BANK)
            |=> REG_RDATA[7:4] == 4'h0;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("no address pulse after a taken operand");
    a_inherent: assert property (p_inherent)
        else $error("address pulse for an operand-free instruction");
    a_banked: assert property (p_banked)
        else $error("banked address is not bank joined to file field");
    a_indexed: assert property (p_indexed)
        else $error("low forced field did not select offset mode");
    a_forced: assert property (p_forced)
        else $error("high forced field did not map to the top bank");
    a_std: assert property (p_std)
        else $error("standard forced field mapped to the wrong bank");
    a_no_idx: assert property (p_no_idx)
        else $error("offset mode used while the extended set is off");
    a_dest_w: assert property (p_dest_w)
        else $error("working register write flag wrong");
    a_dest_f: assert property (p_dest_f)
        else $error("file write flag wrong");
    a_hi_nibble: assert property (p_hi_nibble)
        else $error("pointer high byte upper nibble not zero");
    c_indexed: cover property (ADDR_VALID && ADDR_MODE == DOPAG_MODE_INDEXED);
    c_indirect: cover property (ADDR_VALID && ADDR_MODE == DOPAG_MODE_INDIRECT);
    c_banked: cover property (ADDR_VALID && ADDR_MODE == DOPAG_MODE_BANKED);
endmodule
bind dopag_top dopag_top_properties #(.REG_AW(REG_AW)) u_props (.CLK, .RST_N,
    .CE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .OP_VALID,
    .OPCODE, .OP_FILE_REF, .OP_HAS_DEST, .W_VALUE, .ADDR_VALID, .DATA_ADDR,
    .ADDR_MODE, .WR_TO_FILE, .WR_TO_W);

// ---- dopag_top_tb.sv ----
`timescale 1ns/10ps
module dopag_top_tb;
    import dopag_pkg::*;
    logic CLK, RST_N, CE, REG_WR, REG_RD, go, acc, dst, fr, hd;
    logic OP_VALID, OP_FILE_REF, OP_HAS_DEST, ADDR_VALID, WR_TO_FILE, WR_TO_W;
    logic [3:0] REG_ADDR, bank;
    logic [7:0] REG_WDATA, REG_RDATA, f, w, W_VALUE;
    logic [5:0] hi;
    logic [15:0] OPCODE;
    logic [11:0] DATA_ADDR, e_a;
    logic [11:0] ptr [3];
    logic [11:0] ibase [3];
    dopag_mode_t ADDR_MODE, e_m;
    logic ext, e_v, e_f, e_w;
    int err_count, n_compared, cyc, i, n;
    dopag_top #(.REG_AW(4)) DUT (.CLK, .RST_N, .CE, .REG_ADDR, .REG_WDATA,
        .REG_WR, .REG_RD, .REG_RDATA, .OP_VALID, .OPCODE, .OP_FILE_REF,
        .OP_HAS_DEST, .W_VALUE, .ADDR_VALID, .DATA_ADDR, .ADDR_MODE,
        .WR_TO_FILE, .WR_TO_W);
    dopag_decoder_model u_dec (.go, .acc, .dst, .fr, .hd, .f, .w, .hi,
        .op_valid(OP_VALID), .opcode(OPCODE), .op_file_ref(OP_FILE_REF),
        .op_has_dest(OP_HAS_DEST), .w_value(W_VALUE));
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
        if (a == REG_CFG) ext = d[0];
        if (a == REG_BANK) bank = d[3:0];
        if (a < 4'h6 && !a[0]) ptr[a[2:1]][7:0] = d;
        if (a < 4'h6 && a[0]) ptr[a[2:1]][11:8] = d[3:0];
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 chk({4'h0, REG_RDATA}, {4'h0, exp});
    endtask
    // Expected resolution; updates the pointer shadow like the hardware.
    function automatic void resolve(input logic a, input logic [7:0] fv,
            input logic [7:0] wv);
        logic [11:0] k;
        if (a) begin
            e_a = {bank, fv};
            e_m = DOPAG_MODE_BANKED;
        end else if (ext && fv <= IDX_LIMIT) begin
            e_a = ptr[2] + {4'h0, fv};
            e_m = DOPAG_MODE_INDEXED;
        end else begin
            e_m = DOPAG_MODE_ACCESS;
            e_a = {(ext || fv >= ACC_SPLIT_STD) ? BANK_TOP : BANK_ZERO, fv};
        end
        for (int p = 0; p < 3; p++) begin
            k = e_a - ibase[p];
            if (e_m != DOPAG_MODE_INDEXED && e_m != DOPAG_MODE_INDIRECT
                    && k < 12'h005) begin
                e_m = DOPAG_MODE_INDIRECT;
                e_a = ptr[p];
                case (k)
                    12'h000: e_a = ptr[p] + {{4{wv[7]}}, wv};
                    12'h001: begin
                        ptr[p] = ptr[p] + PTR_STEP;
                        e_a = ptr[p];
                    end
                    12'h002: ptr[p] = ptr[p] - PTR_STEP;
                    12'h003: ptr[p] = ptr[p] + PTR_STEP;
                    default: e_a = ptr[p];
                endcase
            end
        end
    endfunction
    task automatic check_prev;
        chk({11'h0, ADDR_VALID}, {11'h0, e_v});
        if (e_v) begin
            chk(DATA_ADDR, e_a);
            chk({9'h0, ADDR_MODE}, {9'h0, e_m});
            chk({10'h0, WR_TO_FILE, WR_TO_W}, {10'h0, e_f, e_w});
        end
    endtask
    task automatic op(input logic a, input logic d, input logic [7:0] fv,
            input logic [7:0] wv, input logic fri, input logic hdi,
            input logic en);
        @(posedge CLK);
        go <= 1'b1;
        acc <= a;
        dst <= d;
        f <= fv;
        w <= wv;
        fr <= fri;
        hd <= hdi;
        CE <= en;
        hi <= 6'($urandom);
        #1 check_prev;
        // A low enable freezes the outputs, so the last expectations stand.
        if (en) begin
            e_v = fri;
            e_f = !hdi || d;
            e_w = hdi && !d;
            if (e_v) resolve(a, fv, wv);
        end
    endtask
    task automatic flush;
        @(posedge CLK);
        go <= 1'b0;
        CE <= 1'b1;
        #1 check_prev;
        e_v = 1'b0;
    endtask
    task automatic rnd_ops(input int cnt, input logic fr_rand);
        repeat (cnt) op(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom),
            fr_rand ? 1'($urandom) : 1'b1, 1'($urandom), 1'b1);
        flush;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            give_verdict;
        end
    end
    initial begin
        RST_N = 1'b0;
        CE = 1'b1;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 4'h0;
        REG_WDATA = 8'h00;
        go = 1'b0;
        acc = 1'b0;
        dst = 1'b0;
        fr = 1'b0;
        hd = 1'b0;
        f = 8'h00;
        w = 8'h00;
        hi = 6'h00;
        ext = 1'b0;
        bank = 4'h0;
        e_v = 1'b0;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        ibase = '{IND_BASE0, IND_BASE1, IND_BASE2};
        ptr = '{PTR_RST, PTR_RST, PTR_RST};
        void'($urandom(32'hc9cb5cf8));
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        for (i = 0; i < 11; i++) rd(4'(i), 8'h00);
        wr(REG_P0_HI, 8'hf3);
        rd(REG_P0_HI, 8'h03);
        wr(4'ha, 8'hff);
        rd(4'ha, 8'h00);
        $display("test registers done");
        for (i = 0; i < 7; i++) wr(4'(i), 8'($urandom));
        rnd_ops(200, 1'b0);
        $display("test standard done");
        wr(REG_CFG, 8'h01);
        wr(REG_P2_LO, 8'hf0);
        wr(REG_P2_HI, 8'h0f);
        op(1'b0, 1'b1, IDX_LIMIT, 8'h00, 1'b1, 1'b1, 1'b1);
        op(1'b0, 1'b0, ACC_SPLIT_EXT, 8'h00, 1'b1, 1'b1, 1'b1);
        op(1'b0, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
        op(1'b1, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
        rnd_ops(300, 1'b0);
        $display("test extended done");
        wr(REG_BANK, 8'h0f);
        for (n = 0; n < 4; n++) begin
            wr(REG_CFG, 8'(n[0]));
            for (i = 0; i < 15; i++) op(n[1], 1'($urandom), 8'(8'hdb + i),
                8'($urandom), 1'b1, 1'b1, 1'b1);
            flush;
        end
        rd(REG_LAST_LO, e_a[7:0]);
        rd(REG_LAST_HI, {1'b0, e_m, e_a[11:8]});
        $display("test indirect done");
        rnd_ops(60, 1'b1);
        op(1'b1, 1'b0, 8'h10, 8'h00, 1'b1, 1'b1, 1'b1);
        op(1'b1, 1'b1, 8'h20, 8'h00, 1'b1, 1'b1, 1'b0);
        flush;
        $display("test inherent and enable done");
        give_verdict;
    end
endmodule
